// [rtl/tsm_pkg.sv]
package tsm_pkg;

  // Register byte addresses
  localparam logic [15:0] ADDR_SYNC_MUX   = 16'h0109;
  localparam logic [15:0] ADDR_TX_SIG_DL  = 16'h010A;
  localparam logic [15:0] ADDR_STATUS     = 16'h0110;
  localparam logic [15:0] ADDR_FORMAT     = 16'h0111;

  // Reset values
  localparam logic [7:0] SYNC_MUX_RST  = 8'h00;
  localparam logic [7:0] TX_SIG_DL_RST = 8'h00;
  localparam logic [7:0] FORMAT_RST    = 8'h04;

  // Field positions in sync_mux_control
  localparam int SMR_FBIT_SRC_BIT = 0;
  localparam int SMR_CRC_SRC_BIT  = 1;
  localparam logic [7:0] SMR_RD_MASK = 8'h03;

  // Field positions in tx_signaling_link_select
  localparam int TSDL_LSRC_LO = 0;
  localparam int TSDL_DE_LO   = 2;
  localparam int TSDL_BW_LO   = 4;
  localparam logic [7:0] TSDL_RD_MASK = 8'h3F;

  // Field positions in the format control register
  localparam int FMT_SEL_LO    = 0;
  localparam int FMT_ALIGN_BIT = 2;
  localparam logic [7:0] FMT_RD_MASK = 8'h07;

  // Field codes
  localparam logic [1:0] BW_EVERY  = 2'h0;
  localparam logic [1:0] BW_ODD    = 2'h1;
  localparam logic [1:0] BW_EVEN   = 2'h2;
  localparam logic [1:0] DE_SERIAL = 2'h0;
  localparam logic [1:0] DE_LAPD   = 2'h1;
  localparam logic [1:0] DE_FRACT  = 2'h3;
  localparam logic [1:0] DL_LAPD   = 2'h0;
  localparam logic [1:0] DL_SERIAL = 2'h1;
  localparam logic [1:0] DL_OHEAD  = 2'h2;
  localparam logic [1:0] DL_ONES   = 2'h3;

  // Frame geometry
  localparam logic [7:0] LAST_BIT_POS = 8'hC0;
  localparam logic [7:0] ONE_BIT      = 8'h01;
  localparam logic [4:0] LAST_FRAME   = 5'h17;
  localparam logic [4:0] SF_LEN       = 5'h0C;
  localparam logic [4:0] DE_SLOT      = 5'h17;
  localparam logic [1:0] MOD4_CRC     = 2'h1;
  localparam logic [1:0] MOD4_DL_ODD  = 2'h0;
  localparam logic [1:0] MOD4_DL_EVEN = 2'h2;
  localparam logic [2:0] CRC_MSB      = 3'h5;

  // Framing patterns, bit i is the i-th framing bit of the group
  localparam logic [5:0] ESF_FAS_PAT = 6'h34;
  localparam logic [5:0] SF_FT_PAT   = 6'h15;
  localparam logic [5:0] SF_FS_PAT   = 6'h1C;

  // CRC-6 generator taps below the top term
  localparam logic [5:0] CRC6_POLY = 6'h03;
  localparam logic [5:0] CRC6_INIT = 6'h00;

  // Framing formats
  typedef enum logic [1:0] {
    FMT_ESF,
    FMT_SF,
    FMT_SLC96,
    FMT_N
  } tsm_format_t;

  // Kind of bit at the current frame position
  typedef enum logic [2:0] {
    OH_PAYLOAD,
    OH_FAS,
    OH_CRC,
    OH_FDL,
    OH_SPARE
  } tsm_oh_kind_t;

endpackage

// [rtl/tsm_sync.sv]
module tsm_sync (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  // Level from another domain
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_r;
  logic sync_r;

  // Two-stage synchroniser; only the second stage is read
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

// [rtl/tsm_crc6.sv]
module tsm_crc6 (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  // Serial input
  input  wire logic       bit_en_in,
  input  wire logic       restart_in,
  input  wire logic       data_in,
  // Remainder so far
  output logic [5:0]      crc_out
);

  logic [5:0] crc_r;
  logic [5:0] base;
  logic       fb;

  // Restart folds the first bit into a fresh remainder
  always_comb begin
    base = restart_in ? tsm_pkg::CRC6_INIT : crc_r;
    fb   = data_in ^ base[5];
  end

  // Serial division by x^6 + x + 1
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      crc_r <= tsm_pkg::CRC6_INIT;
    end else if (bit_en_in) begin
      crc_r <= {base[4:0], 1'b0} ^ (fb ? tsm_pkg::CRC6_POLY : tsm_pkg::CRC6_INIT);
    end
  end

  assign crc_out = crc_r;

endmodule

// [rtl/tsm_tx_overhead_mux.sv]
// Overview of operation
// RULE1: CRC select 0 sends internally computed CRC-6
// RULE2: CRC select 1 passes serial input bits
// RULE3: CRC select ignored without multiframe alignment
// RULE4: Framing select 0 inserts internal framing bits
// RULE5: Framing select 1 takes framing from serial
// RULE6: Bandwidth 00 gives link bit every frame; the code gives it only in the odd frames 1, 3, 5, ... (even frame_r)
// RULE7: Bandwidth 01 uses frames 1, 5, 9
// RULE8: Bandwidth 10 uses frames 3, 7, 11
// RULE9: Bandwidth only in ESF; SLC96 stays 4kHz
// RULE10: N format link always 8kHz
// RULE11: D/E source field defaults to serial
// RULE12: D/E slots may pass serial data
// RULE13: D/E slots may carry link-layer controller bits
// RULE14: D/E slots may come from fractional pin
// RULE15: D/E code 10 behaves as serial
// RULE16: Link source: controller, serial, overhead, ones
// RULE17: Software avoids reserved field codes
module tsm_tx_overhead_mux (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  // Register port
  input  wire logic [15:0] reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out,
  // Backplane pins
  input  wire logic        tx_ser_clk_in,
  input  wire logic        tx_serial_data_in,
  input  wire logic        tx_overhead_in,
  input  wire logic        tx_fractional_in,
  // Link-layer controller side
  input  wire logic        lapd_dl_bit_in,
  input  wire logic        slc96_dl_bit_in,
  input  wire logic        lapd_de_bit_in,
  output logic             dl_bit_take_out,
  output logic             de_bit_take_out,
  // Outbound line stream
  output logic             tx_line_data_out,
  output logic             tx_line_fbit_out,
  output logic             tx_line_strobe_out
);

  // Decodes a register hit for one address
  function automatic logic reg_hit(input logic [15:0] addr,
                                   input logic [15:0] offset);
    reg_hit = (addr == offset);
  endfunction

  logic [7:0]             sync_mux_r;
  logic [7:0]             tx_sig_dl_r;
  logic [7:0]             format_r;
  logic [7:0]             rdata_r;
  logic [3:0]             pin_raw;
  logic [3:0]             pin_sync;
  logic                   clk_d_r;
  logic                   link_edge;
  logic                   ser_bit;
  logic                   oh_bit;
  logic                   fract_bit;
  logic [7:0]             bit_pos_r;
  logic [7:0]             bit_pos_nxt;
  logic [4:0]             frame_r;
  logic [4:0]             frame_nxt;
  logic [7:0]             pay_off;
  logic [4:0]             slot_idx;
  logic [4:0]             sf_idx;
  logic [2:0]             grp;
  logic                   f_pos;
  logic                   de_pos;
  logic                   mf_start;
  tsm_pkg::tsm_format_t   fmt;
  tsm_pkg::tsm_oh_kind_t  oh_kind;
  logic                   pat_bit;
  logic                   out_bit;
  logic                   dl_bit;
  logic                   de_bit;
  logic [1:0]             bw_sel;
  logic [1:0]             de_src;
  logic [1:0]             dl_src;
  logic                   fbit_ext;
  logic                   crc_ext;
  logic                   crc_align_en;
  logic [5:0]             crc_val;
  logic [5:0]             crc_hold_r;
  logic                   line_data_r;
  logic                   line_fbit_r;
  logic                   line_strobe_r;

  // Field views of the configuration registers
  assign bw_sel       = tx_sig_dl_r[tsm_pkg::TSDL_BW_LO +: 2];
  assign de_src       = tx_sig_dl_r[tsm_pkg::TSDL_DE_LO +: 2];
  assign dl_src       = tx_sig_dl_r[tsm_pkg::TSDL_LSRC_LO +: 2];
  assign fbit_ext     = sync_mux_r[tsm_pkg::SMR_FBIT_SRC_BIT];
  assign crc_ext      = sync_mux_r[tsm_pkg::SMR_CRC_SRC_BIT];
  assign crc_align_en = format_r[tsm_pkg::FMT_ALIGN_BIT];
  assign fmt          = tsm_pkg::tsm_format_t'(format_r[tsm_pkg::FMT_SEL_LO +: 2]);

  // Register writes
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_mux_r  <= tsm_pkg::SYNC_MUX_RST;
      tx_sig_dl_r <= tsm_pkg::TX_SIG_DL_RST; // RULE11
      format_r    <= tsm_pkg::FORMAT_RST;
    end else if (reg_wr_in) begin
      if (reg_hit(reg_addr_in, tsm_pkg::ADDR_SYNC_MUX)) begin
        sync_mux_r <= reg_wdata_in & tsm_pkg::SMR_RD_MASK;
      end else if (reg_hit(reg_addr_in, tsm_pkg::ADDR_TX_SIG_DL)) begin
        tx_sig_dl_r <= reg_wdata_in & tsm_pkg::TSDL_RD_MASK;
      end else if (reg_hit(reg_addr_in, tsm_pkg::ADDR_FORMAT)) begin
        format_r <= reg_wdata_in & tsm_pkg::FMT_RD_MASK;
      end
    end
  end

  // Register reads, data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_in) begin
      if (reg_hit(reg_addr_in, tsm_pkg::ADDR_SYNC_MUX)) begin
        rdata_r <= sync_mux_r;
      end else if (reg_hit(reg_addr_in, tsm_pkg::ADDR_TX_SIG_DL)) begin
        rdata_r <= tx_sig_dl_r;
      end else if (reg_hit(reg_addr_in, tsm_pkg::ADDR_FORMAT)) begin
        rdata_r <= format_r;
      end else if (reg_hit(reg_addr_in, tsm_pkg::ADDR_STATUS)) begin
        rdata_r <= {3'h0, frame_r};
      end else begin
        rdata_r <= 8'h00;
      end
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata_out = rdata_r;

  // Backplane pins pass two flip-flops each
  assign pin_raw = {tx_fractional_in, tx_overhead_in, tx_serial_data_in, tx_ser_clk_in};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      tsm_sync u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   (pin_raw[gi]),
        .sync_out   (pin_sync[gi])
      );
    end
  endgenerate

  assign ser_bit   = pin_sync[1];
  assign oh_bit    = pin_sync[2];
  assign fract_bit = pin_sync[3];

  // Rising edge of the backplane serial clock
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_d_r <= 1'b0;
    end else begin
      clk_d_r <= pin_sync[0];
    end
  end

  assign link_edge = pin_sync[0] & ~clk_d_r;

  // Next bit position and frame number
  always_comb begin
    bit_pos_nxt = bit_pos_r + tsm_pkg::ONE_BIT;
    frame_nxt   = frame_r;
    if (bit_pos_r == tsm_pkg::LAST_BIT_POS) begin
      bit_pos_nxt = 8'h00;
      frame_nxt   = (frame_r == tsm_pkg::LAST_FRAME) ? 5'h00 : frame_r + 5'h01;
    end
  end

  // Frame position counters advance on each backplane bit
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bit_pos_r <= 8'h00;
      frame_r   <= 5'h00;
    end else if (link_edge) begin
      bit_pos_r <= bit_pos_nxt;
      frame_r   <= frame_nxt;
    end
  end

  // Position decoding
  assign f_pos    = (bit_pos_r == 8'h00);
  assign pay_off  = bit_pos_r - tsm_pkg::ONE_BIT;
  assign slot_idx = pay_off[7:3];
  assign de_pos   = !f_pos && (slot_idx == tsm_pkg::DE_SLOT);
  assign grp      = frame_r[4:2];
  assign sf_idx   = (frame_r >= tsm_pkg::SF_LEN) ? frame_r - tsm_pkg::SF_LEN : frame_r;
  assign mf_start = f_pos && (frame_r == 5'h00);

  // Classifies the current bit and picks the internal framing pattern
  always_comb begin
    oh_kind = tsm_pkg::OH_PAYLOAD;
    pat_bit = 1'b1;
    if (f_pos) begin
      case (fmt)
        tsm_pkg::FMT_ESF: begin
          if (!frame_r[0]) begin
            case (bw_sel)
              tsm_pkg::BW_ODD: begin
                oh_kind = (frame_r[1:0] == tsm_pkg::MOD4_DL_ODD) ?
                          tsm_pkg::OH_FDL : tsm_pkg::OH_SPARE; // RULE7
              end
              tsm_pkg::BW_EVEN: begin
                oh_kind = (frame_r[1:0] == tsm_pkg::MOD4_DL_EVEN) ?
                          tsm_pkg::OH_FDL : tsm_pkg::OH_SPARE; // RULE8
              end
              default: begin
                oh_kind = tsm_pkg::OH_FDL; // RULE6 RULE17
              end
            endcase
          end else if (frame_r[1:0] == tsm_pkg::MOD4_CRC) begin
            oh_kind = tsm_pkg::OH_CRC;
          end else begin
            oh_kind = tsm_pkg::OH_FAS;
            pat_bit = tsm_pkg::ESF_FAS_PAT[grp];
          end
        end
        tsm_pkg::FMT_SF: begin
          oh_kind = tsm_pkg::OH_FAS;
          pat_bit = sf_idx[0] ? tsm_pkg::SF_FS_PAT[sf_idx[3:1]] :
                                tsm_pkg::SF_FT_PAT[sf_idx[3:1]];
        end
        tsm_pkg::FMT_SLC96: begin
          if (sf_idx[0]) begin
            oh_kind = tsm_pkg::OH_FDL; // RULE9
          end else begin
            oh_kind = tsm_pkg::OH_FAS;
            pat_bit = tsm_pkg::SF_FT_PAT[sf_idx[3:1]];
          end
        end
        default: begin
          oh_kind = tsm_pkg::OH_FDL; // RULE10
        end
      endcase
    end
  end

  // Data link bit source
  always_comb begin
    case (dl_src)
      tsm_pkg::DL_LAPD: begin
        dl_bit = (fmt == tsm_pkg::FMT_SLC96) ? slc96_dl_bit_in : lapd_dl_bit_in; // RULE16
      end
      tsm_pkg::DL_SERIAL: begin
        dl_bit = ser_bit; // RULE16
      end
      tsm_pkg::DL_OHEAD: begin
        dl_bit = oh_bit; // RULE16
      end
      default: begin
        dl_bit = 1'b1; // RULE16
      end
    endcase
  end

  // D/E timeslot source
  always_comb begin
    case (de_src)
      tsm_pkg::DE_LAPD: begin
        de_bit = lapd_de_bit_in; // RULE13
      end
      tsm_pkg::DE_FRACT: begin
        de_bit = fract_bit; // RULE14
      end
      default: begin
        de_bit = ser_bit; // RULE12 RULE15
      end
    endcase
  end

  // Outgoing bit selection
  always_comb begin
    case (oh_kind)
      tsm_pkg::OH_FAS: begin
        out_bit = fbit_ext ? ser_bit : pat_bit; // RULE4 RULE5
      end
      tsm_pkg::OH_CRC: begin
        if (crc_ext && crc_align_en) begin
          out_bit = ser_bit; // RULE2 RULE3
        end else begin
          out_bit = crc_hold_r[tsm_pkg::CRC_MSB - grp]; // RULE1
        end
      end
      tsm_pkg::OH_FDL: begin
        out_bit = dl_bit;
      end
      tsm_pkg::OH_SPARE: begin
        out_bit = 1'b1;
      end
      default: begin
        out_bit = de_pos ? de_bit : ser_bit;
      end
    endcase
  end

  // CRC-6 over each multiframe, framing bits counted as ones
  tsm_crc6 u_crc6 (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .bit_en_in  (link_edge),
    .restart_in (mf_start),
    .data_in    (f_pos | out_bit),
    .crc_out    (crc_val)
  );

  // Remainder of the finished multiframe goes into the next one
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      crc_hold_r <= tsm_pkg::CRC6_INIT;
    end else if (link_edge && mf_start) begin
      crc_hold_r <= crc_val; // RULE1
    end
  end

  // Line outputs registered on each backplane bit
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_data_r   <= 1'b1;
      line_fbit_r   <= 1'b0;
      line_strobe_r <= 1'b0;
    end else begin
      line_strobe_r <= link_edge;
      if (link_edge) begin
        line_data_r <= out_bit;
        line_fbit_r <= f_pos;
      end
    end
  end

  assign tx_line_data_out   = line_data_r;
  assign tx_line_fbit_out   = line_fbit_r;
  assign tx_line_strobe_out = line_strobe_r;

  // Take strobes tell a controller its bit was consumed
  assign dl_bit_take_out = link_edge && (oh_kind == tsm_pkg::OH_FDL) &&
                           (dl_src == tsm_pkg::DL_LAPD);
  assign de_bit_take_out = link_edge && (oh_kind == tsm_pkg::OH_PAYLOAD) && de_pos &&
                           (de_src == tsm_pkg::DE_LAPD); // RULE13

endmodule

// [testbench/tsm_tx_overhead_mux_chk.sv]
module tsm_tx_overhead_mux_chk (
  // Clock and reset
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  // Register writes
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_wr_in,
  // Backplane and controller side
  input wire logic        tx_ser_clk_in,
  input wire logic        dl_bit_take_out,
  input wire logic        de_bit_take_out,
  // Line
  input wire logic        tx_line_data_out,
  input wire logic        tx_line_fbit_out,
  input wire logic        tx_line_strobe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pos_r;
  logic [4:0] frm_r;
  logic [7:0] ts_r;
  logic [1:0] fm_r;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  // Bit and frame position of the line output, counted from strobes
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pos_r <= 8'h00;
      frm_r <= 5'h00;
    end else if (tx_line_strobe_out) begin
      pos_r <= (pos_r == tsm_pkg::LAST_BIT_POS) ? 8'h00 : pos_r + 8'h01;
      if (pos_r == tsm_pkg::LAST_BIT_POS) begin
        frm_r <= (frm_r == tsm_pkg::LAST_FRAME) ? 5'h00 : frm_r + 5'h01;
      end
    end
  end

  // Shadow copies of link select and format
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ts_r <= 8'h00;
      fm_r <= 2'h0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == tsm_pkg::ADDR_TX_SIG_DL) ts_r <= reg_wdata_in;
      if (reg_addr_in == tsm_pkg::ADDR_FORMAT) fm_r <= reg_wdata_in[1:0];
    end
  end

  line_timing_a: assert property ($rose(tx_ser_clk_in) |-> ##[2:4] tx_line_strobe_out)
    else $error("line bit not sent after serial clock edge");
  fbit_place_a: assert property (tx_line_strobe_out |-> tx_line_fbit_out == (pos_r == 8'h00))
    else $error("framing flag off its position");
  ones_src_a: assert property (tx_line_strobe_out && pos_r == 8'h00 && !frm_r[0]
    && fm_r == 2'h0 && ts_r[5:0] == 6'h03 |-> tx_line_data_out) else $error("link bit not one");
  dl_take_a: assert property (dl_bit_take_out |=> tx_line_strobe_out && tx_line_fbit_out)
    else $error("link take outside framing bit");
  bw_odd_a: assert property (dl_bit_take_out && fm_r == 2'h0 && ts_r[5:4] == 2'h1
    |=> frm_r[1:0] == tsm_pkg::MOD4_DL_ODD) else $error("odd bandwidth take in wrong frame");
  bw_even_a: assert property (dl_bit_take_out && fm_r == 2'h0 && ts_r[5:4] == 2'h2
    |=> frm_r[1:0] == tsm_pkg::MOD4_DL_EVEN) else $error("even bandwidth take in wrong frame");
  de_take_a: assert property (de_bit_take_out |=> tx_line_strobe_out && pos_r >= 8'hB9)
    else $error("slot take outside slot");
  de_select_a: assert property (ts_r[3:2] != tsm_pkg::DE_LAPD |-> !de_bit_take_out)
    else $error("slot take without controller source");
endmodule

bind tsm_tx_overhead_mux tsm_tx_overhead_mux_chk u_tsm_tx_overhead_mux_chk (.ref_clk_in,
  .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .tx_ser_clk_in, .dl_bit_take_out,
  .de_bit_take_out, .tx_line_data_out, .tx_line_fbit_out, .tx_line_strobe_out);

// [testbench/tsm_backplane_model.sv]
module tsm_backplane_model (
  // Values from the bench
  input  wire logic rst_n_in,
  input  wire logic payload_in,
  input  wire logic fbit_in,
  // Backplane pins
  output logic      ser_clk_out,
  output logic      ser_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos;

  // Serial clock, still during reset so bit counts agree
  initial begin
    ser_clk_out = 1'b0;
    forever #100 ser_clk_out = rst_n_in ? ~ser_clk_out : 1'b0;
  end

  // Bit position, advanced by each rising edge
  always @(posedge ser_clk_out or negedge rst_n_in) begin
    if (!rst_n_in) pos <= 0;
    else pos <= (pos == 192) ? 0 : pos + 1;
  end

  // Data launched on the falling edge, framing value at bit 0
  always @(negedge ser_clk_out or negedge rst_n_in) begin
    ser_data_out <= (pos == 0) ? fbit_in : payload_in;
  end
endmodule

// [testbench/tsm_tx_overhead_mux_tb_top.sv]
module tsm_tx_overhead_mux_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_in;
  logic        rst_n_in;
  logic [15:0] reg_addr_in;
  logic [7:0]  reg_wdata_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  logic [7:0]  reg_rdata_out;
  logic        tx_ser_clk_in;
  logic        tx_serial_data_in;
  logic        tx_overhead_in;
  logic        tx_fractional_in;
  logic        lapd_dl_bit_in;
  logic        slc96_dl_bit_in;
  logic        lapd_de_bit_in;
  logic        dl_bit_take_out;
  logic        de_bit_take_out;
  logic        tx_line_data_out;
  logic        tx_line_fbit_out;
  logic        tx_line_strobe_out;
  logic        sd;
  logic        fb;
  logic        e;
  logic        chk;
  logic [7:0]  sm;
  logic [7:0]  ts;
  logic [7:0]  fm;
  logic [5:0]  crc;
  logic [5:0]  crcp;
  int          pos;
  int          frm;
  int          fcnt;
  int          mismatches;
  int          total_checks;

  tsm_tx_overhead_mux u_tsm_tx_overhead_mux (.ref_clk_in, .rst_n_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .tx_ser_clk_in, .tx_serial_data_in,
    .tx_overhead_in, .tx_fractional_in, .lapd_dl_bit_in, .slc96_dl_bit_in, .lapd_de_bit_in,
    .dl_bit_take_out, .de_bit_take_out, .tx_line_data_out, .tx_line_fbit_out,
    .tx_line_strobe_out);
  tsm_backplane_model u_tsm_backplane_model (.rst_n_in, .payload_in(sd), .fbit_in(fb),
    .ser_clk_out(tx_ser_clk_in), .ser_data_out(tx_serial_data_in));

  // Reference clock
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  task automatic finish_test();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(string name, logic [7:0] x, logic [7:0] got);
    total_checks++;
    if (got !== x) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, x, got);
    end
  endtask

  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(logic [15:0] a, logic [7:0] x);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1 check("rdata", x, reg_rdata_out);
  endtask

  // Expected line bit from the mirrored settings and the driven inputs
  function automatic logic exp_bit(int p, int f);
    logic dl;
    dl = (ts[1:0] == 2'h0) ? ((fm[1:0] == 2'h2) ? slc96_dl_bit_in : lapd_dl_bit_in)
       : (ts[1:0] == 2'h1) ? fb : (ts[1:0] == 2'h2) ? tx_overhead_in : 1'b1;
    if (p >= 185) return (ts[3:2] == 2'h1) ? lapd_de_bit_in
                       : (ts[3:2] == 2'h3) ? tx_fractional_in : sd;
    if (p != 0) return sd;
    if (fm[1:0] == 2'h3) return dl;
    if (fm[1:0] == 2'h2) return (f % 2) ? dl : (sm[0] ? fb : tsm_pkg::SF_FT_PAT[(f % 12) / 2]);
    if (fm[1:0] == 2'h1) return sm[0] ? fb : ((f % 2) ? tsm_pkg::SF_FS_PAT[(f % 12) / 2]
                                                     : tsm_pkg::SF_FT_PAT[(f % 12) / 2]);
    if (f % 2 == 0) return ((ts[5:4] == 2'h1 && f % 4 != 0)
                           || (ts[5:4] == 2'h2 && f % 4 != 2)) ? 1'b1 : dl;
    if (f % 4 == 1) return (sm[1] && fm[2]) ? fb : crcp[5 - f / 4];
    return sm[0] ? fb : tsm_pkg::ESF_FAS_PAT[f / 4];
  endfunction

  // Line monitor with running CRC of each multiframe, framing bits as one
  always @(posedge ref_clk_in) begin
    if (tx_line_strobe_out === 1'b1) begin
      e = exp_bit(pos, frm);
      if (chk) check("line_bit", {7'h00, e}, {7'h00, tx_line_data_out});
      crc = {crc[4:0], 1'b0} ^ ({6{crc[5] ^ (pos == 0 || tx_line_data_out)}} & tsm_pkg::CRC6_POLY);
      if (pos == 192) begin
        pos = 0;
        crcp = (frm == 23) ? crc : crcp;
        crc = (frm == 23) ? 6'h00 : crc;
        frm = (frm + 1) % 24;
      end else begin
        pos++;
        fcnt += (pos == 1);
      end
    end
  end

  // New settings before frame k; v is serial, framing, overhead, fractional, three controller bits
  task automatic cfg(int k, logic [7:0] s, logic [7:0] t, logic [7:0] f, logic [6:0] v);
    wait (fcnt >= k);
    chk = 1'b0;
    sm = s;
    ts = t;
    fm = f;
    wr(tsm_pkg::ADDR_SYNC_MUX, s);
    wr(tsm_pkg::ADDR_TX_SIG_DL, t);
    wr(tsm_pkg::ADDR_FORMAT, f);
    {sd, fb, tx_overhead_in, tx_fractional_in, lapd_dl_bit_in, slc96_dl_bit_in,
     lapd_de_bit_in} <= v;
    repeat (20) @(posedge tx_line_strobe_out);
    chk = 1'b1;
  endtask

  task automatic test_regs();
    rd(tsm_pkg::ADDR_SYNC_MUX, 8'h00);
    rd(tsm_pkg::ADDR_TX_SIG_DL, 8'h00);
    rd(tsm_pkg::ADDR_FORMAT, tsm_pkg::FORMAT_RST);
    rd(tsm_pkg::ADDR_STATUS, 8'h00);
    wr(tsm_pkg::ADDR_SYNC_MUX, 8'hFF);
    rd(tsm_pkg::ADDR_SYNC_MUX, 8'h03);
    wr(tsm_pkg::ADDR_TX_SIG_DL, 8'hFF);
    rd(tsm_pkg::ADDR_TX_SIG_DL, 8'h3F);
    wr(16'h0108, 8'hFF);
    rd(16'h0108, 8'h00);
    wr(tsm_pkg::ADDR_SYNC_MUX, 8'h00);
    wr(tsm_pkg::ADDR_TX_SIG_DL, 8'h00);
  endtask

  task automatic test_bw();
    cfg(1, 8'h00, 8'h00, 8'h04, 7'h40);
    cfg(8, 8'h02, 8'h10, 8'h04, 7'h60);
    cfg(16, 8'h00, 8'h20, 8'h04, 7'h40);
    wait (fcnt >= 24);
  endtask

  task automatic test_dl_src();
    cfg(24, 8'h00, 8'h00, 8'h04, 7'h40);
    cfg(28, 8'h00, 8'h01, 8'h04, 7'h44);
    cfg(32, 8'h00, 8'h03, 8'h04, 7'h40);
    cfg(36, 8'h00, 8'h02, 8'h04, 7'h50);
    cfg(40, 8'h01, 8'h00, 8'h04, 7'h44);
    wait (fcnt >= 48);
  endtask

  task automatic test_formats();
    cfg(48, 8'h02, 8'h00, 8'h00, 7'h40);
    cfg(50, 8'h00, 8'h15, 8'h07, 7'h01);
    cfg(51, 8'h00, 8'h1C, 8'h06, 7'h0C);
    cfg(53, 8'h00, 8'h1C, 8'h05, 7'h0C);
    cfg(54, 8'h00, 8'h08, 8'h04, 7'h0D);
    wait (fcnt >= 55);
  endtask

  // Stimulus: reset, then scenarios in frame order
  initial begin
    rst_n_in = 1'b0;
    reg_addr_in = 16'h0000;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    {sd, fb, tx_overhead_in, tx_fractional_in, lapd_dl_bit_in, slc96_dl_bit_in,
     lapd_de_bit_in} = 7'h40;
    {sm, ts, fm, chk, crc, crcp} = {8'h00, 8'h00, 8'h04, 1'b0, 6'h00, 6'h00};
    repeat (16) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    test_regs();
    test_bw();
    test_dl_src();
    test_formats();
    finish_test();
  end

  // Watchdog past the expected 55 frames
  initial begin
    #2400000;
    mismatches++;
    finish_test();
  end
endmodule
